// [src/phy_basic_control_register.sv]
// Basic control register, bits 15 to 6, of a 10/100 PHY management space.
// Assumes a decoded management frame engine gives one-cycle write and read strobes.
// Summary of operation
// - Bit 15 resets PHY, self-clears when done
// - Bit 14 loopback enable, resets zero
// - Bit 13 speed low bit; 01 100M
// - Speed high bit at bit 6
// - Bit 12 negotiation enable, strap default one
// - Bit 11 power-down, default from strap
// - Strapped power-down holds until software clears
// - Bit 10 isolates MAC interface outputs
// - Bit 9 restarts negotiation, self-clears
// - Address 0x0000, reset 0x1000 plus straps
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_register (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic strapNegEnable,
    input wire logic strapPowerDown,
    input wire logic [1:0] strapSpeed,
    input wire logic negRestartDone,
    output logic [15:0] regRdata,
    output logic regRvalid,
    output logic coreReset,
    output logic loopbackEnable,
    output logic [1:0] linkSpeed,
    output logic speedReserved,
    output logic negotiationEnable,
    output logic softPowerDown,
    output logic macIsolate,
    output logic negotiationRestart,
    output logic fullDuplexSelect,
    output logic collisionTest
);
    import phy_ctrl_pkg::*;

    typedef struct packed {
        // Strap pins {negotiation, power-down, speed msb, speed lsb}
        logic [3:0] strapSync1;
        logic [3:0] strapSync2;
        logic [3:0] strapSync3;
        logic strapLoad;
        logic softResetRequest;
        logic loopback;
        logic [1:0] speed;
        logic negEnable;
        logic powerDown;
        logic isolate;
        logic negRestart;
        logic duplex;
        logic colTest;
        logic [15:0] rdata;
        logic rvalid;
    } regs_t;

    regs_t cur_ff;
    regs_t nxt_cur;
    logic seqDone;
    logic seqHold;
    logic [15:0] image;
    logic hit;
    logic softStart;

    // Only address zero is decoded here; other registers live elsewhere
    assign hit = (regAddr == CTRL_ADDR);
    assign softStart = regWrite && hit && regWdata[BIT_SOFT_RESET];

    // A second start is refused while a soft reset is still under way
    soft_reset_sequencer u_seq (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(softStart && !cur_ff.softResetRequest),
        .coreReset(seqHold),
        .done(seqDone)
    );

    // Bits 5 to 0 are not held here and read as zero
    always_comb begin
        image = 16'h0000;
        image[BIT_SOFT_RESET] = cur_ff.softResetRequest;
        image[BIT_LOOPBACK] = cur_ff.loopback;
        image[BIT_SPEED_LSB] = cur_ff.speed[0];
        image[BIT_NEG_ENABLE] = cur_ff.negEnable;
        image[BIT_POWER_DOWN] = cur_ff.powerDown;
        image[BIT_ISOLATE] = cur_ff.isolate;
        image[BIT_NEG_RESTART] = cur_ff.negRestart;
        image[BIT_DUPLEX] = cur_ff.duplex;
        image[BIT_COL_TEST] = cur_ff.colTest;
        image[BIT_SPEED_MSB] = cur_ff.speed[1];
    end

    always_comb begin
        nxt_cur = cur_ff;
        // Straps come from pins: three stages, agreement of last two counts
        nxt_cur.strapSync1 = {strapNegEnable, strapPowerDown, strapSpeed};
        nxt_cur.strapSync2 = cur_ff.strapSync1;
        nxt_cur.strapSync3 = cur_ff.strapSync2;
        nxt_cur.rvalid = 1'b0;
        if (cur_ff.strapLoad && cur_ff.strapSync2 == cur_ff.strapSync3) begin
            // Latched once after each reset release or soft reset, so pin noise in between is ignored
            nxt_cur.strapLoad = 1'b0;
            nxt_cur.negEnable = cur_ff.strapSync3[3];
            nxt_cur.powerDown = cur_ff.strapSync3[2];
            nxt_cur.speed = cur_ff.strapSync3[1:0];
        end else if (regWrite && hit) begin
            nxt_cur.loopback = regWdata[BIT_LOOPBACK];
            nxt_cur.speed = {regWdata[BIT_SPEED_MSB], regWdata[BIT_SPEED_LSB]};
            nxt_cur.negEnable = regWdata[BIT_NEG_ENABLE];
            nxt_cur.powerDown = regWdata[BIT_POWER_DOWN];
            nxt_cur.isolate = regWdata[BIT_ISOLATE];
            nxt_cur.duplex = regWdata[BIT_DUPLEX];
            nxt_cur.colTest = regWdata[BIT_COL_TEST];
            if (regWdata[BIT_NEG_RESTART]) begin
                nxt_cur.negRestart = 1'b1;
            end
            if (regWdata[BIT_SOFT_RESET]) begin
                nxt_cur.softResetRequest = 1'b1;
            end
        end

        // Set wins: a fresh write of one keeps the bit high
        if (negRestartDone && !(regWrite && hit && regWdata[BIT_NEG_RESTART])) begin
            nxt_cur.negRestart = 1'b0;
        end

        if (seqDone) begin
            // Soft reset returns control bits to defaults, straps reapplied
            nxt_cur.softResetRequest = 1'b0;
            nxt_cur.loopback = 1'b0;
            nxt_cur.isolate = 1'b0;
            nxt_cur.negRestart = 1'b0;
            nxt_cur.duplex = 1'b0;
            nxt_cur.colTest = 1'b0;
            nxt_cur.strapLoad = 1'b1;
        end

        // Other addresses answer zero so the frame engine never waits
        if (regRead && hit) begin
            nxt_cur.rdata = image;
            nxt_cur.rvalid = 1'b1;
        end else if (regRead) begin
            nxt_cur.rdata = 16'h0000;
            nxt_cur.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.strapLoad <= 1'b1;
            cur_ff.negEnable <= CTRL_RESET[BIT_NEG_ENABLE];
            // Strap stages keep sampling through reset, so the image is
            // latched from settled pins at the first edge after release
            cur_ff.strapSync1 <= nxt_cur.strapSync1;
            cur_ff.strapSync2 <= cur_ff.strapSync1;
            cur_ff.strapSync3 <= cur_ff.strapSync2;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Controls lag the register by one cycle so every pin leaves a flip-flop
    typedef struct packed {
        logic coreReset;
        logic loopbackEnable;
        logic [1:0] linkSpeed;
        logic speedReserved;
        logic negotiationEnable;
        logic softPowerDown;
        logic macIsolate;
        logic negotiationRestart;
        logic fullDuplexSelect;
        logic collisionTest;
    } outs_t;
    outs_t out_ff;
    outs_t nxt_out;

    always_comb begin
        nxt_out.coreReset = seqHold || cur_ff.softResetRequest;
        nxt_out.loopbackEnable = cur_ff.loopback;
        nxt_out.linkSpeed = cur_ff.speed;
        nxt_out.speedReserved = cur_ff.speed[1];
        nxt_out.negotiationEnable = cur_ff.negEnable;
        // Power-down also held while straps are pending, so core waits for the strap image to latch
        nxt_out.softPowerDown = cur_ff.powerDown || cur_ff.strapLoad;
        nxt_out.macIsolate = cur_ff.isolate;
        nxt_out.negotiationRestart = cur_ff.negRestart;
        nxt_out.fullDuplexSelect = cur_ff.duplex;
        nxt_out.collisionTest = cur_ff.colTest;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_ff <= '0;
            out_ff.coreReset <= 1'b1;
            out_ff.softPowerDown <= 1'b1;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign regRdata = cur_ff.rdata;
    assign regRvalid = cur_ff.rvalid;
    assign coreReset = out_ff.coreReset;
    assign loopbackEnable = out_ff.loopbackEnable;
    assign linkSpeed = out_ff.linkSpeed;
    assign speedReserved = out_ff.speedReserved;
    assign negotiationEnable = out_ff.negotiationEnable;
    assign softPowerDown = out_ff.softPowerDown;
    assign macIsolate = out_ff.macIsolate;
    assign negotiationRestart = out_ff.negotiationRestart;
    assign fullDuplexSelect = out_ff.fullDuplexSelect;
    assign collisionTest = out_ff.collisionTest;
endmodule : phy_basic_control_register
`default_nettype wire

// [src/phy_ctrl_pkg.sv]
// Constants for the PHY basic control register block.
// Assumes a 25 MHz system clock and a 16-bit management register port.
`default_nettype none
package phy_ctrl_pkg;
    localparam logic [4:0] CTRL_ADDR = 5'h00;
    localparam logic [15:0] CTRL_RESET = 16'h1000;
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED_LSB = 13;
    localparam int BIT_NEG_ENABLE = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_NEG_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    localparam int BIT_SPEED_MSB = 6;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam int CLK_HZ = 25000000;
    localparam int CORE_RESET_NS = 400;
    localparam int CORE_RESET_CYC = (CORE_RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] RESET_CYCLES = 8'(CORE_RESET_CYC);
    typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_DONE} rst_state_t;
endpackage : phy_ctrl_pkg
`default_nettype wire

// [src/soft_reset_sequencer.sv]
// Soft reset sequencer: holds the core in reset for a fixed count.
// Assumes start is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module soft_reset_sequencer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    output logic coreReset,
    output logic done
);
    import phy_ctrl_pkg::*;
    typedef struct packed {
        rst_state_t state;
        logic [7:0] count;
        logic hold;
        logic done;
    } seq_t;
    seq_t cur_ff;
    seq_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        case (cur_ff.state)
            ST_IDLE: begin
                if (start) begin
                    nxt_cur.state = ST_RESET;
                    nxt_cur.count = RESET_CYCLES;
                    nxt_cur.hold = 1'b1;
                end
            end
            ST_RESET: begin
                if (cur_ff.count <= 8'h01) begin
                    nxt_cur.state = ST_DONE;
                    nxt_cur.hold = 1'b0;
                end else begin
                    nxt_cur.count = cur_ff.count - 8'h01;
                end
            end
            default: begin
                nxt_cur.state = ST_IDLE;
                nxt_cur.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_ff <= '{state: ST_IDLE, count: 8'h00, hold: 1'b0, done: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign coreReset = cur_ff.hold;
    assign done = cur_ff.done;
endmodule : soft_reset_sequencer
`default_nettype wire

// [test/phy_ctrl_props.sv]
// Port assertions for the basic control register.
// Bound into the register module; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic negRestartDone,
    input wire logic [15:0] regRdata,
    input wire logic regRvalid,
    input wire logic coreReset,
    input wire logic loopbackEnable,
    input wire logic [1:0] linkSpeed,
    input wire logic negotiationEnable,
    input wire logic softPowerDown,
    input wire logic macIsolate,
    input wire logic negotiationRestart,
    input wire logic fullDuplexSelect
);
    // Writes while coreReset is high are left out of the write checks
    logic wrOk;
    assign wrOk = regWrite && regAddr == 5'h00 && !coreReset;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (regRead |=> regRvalid) else $error("read unanswered");
    chk_unmapped_read: assert property (regRead && regAddr != 5'h00 |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_loopback_write: assert property (wrOk |-> ##2 loopbackEnable == $past(regWdata[14], 2))
        else $error("loopback wrong");
    chk_speed_write: assert property (wrOk |-> ##2 linkSpeed == {$past(regWdata[6], 2), $past(regWdata[13], 2)})
        else $error("speed wrong");
    chk_ctrl_write: assert property (wrOk |-> ##2 {negotiationEnable, softPowerDown, macIsolate, fullDuplexSelect}
        == {$past(regWdata[12:10], 2), $past(regWdata[8], 2)}) else $error("control bits wrong");
    chk_reset_hold: assert property ($rose(coreReset) |-> coreReset [*8]) else $error("core reset short");
    chk_reset_clear: assert property (wrOk && regWdata[15] |-> ##2 coreReset ##[9:14] !coreReset)
        else $error("soft reset not run or stuck");
    chk_restart_clear: assert property (negRestartDone && !(wrOk && regWdata[9]) |-> ##2 !negotiationRestart)
        else $error("restart not cleared");
endmodule : phy_ctrl_props
bind phy_basic_control_register phy_ctrl_props props (.*);
`default_nettype wire

// [test/neg_core_model.sv]
// Core-side responder to negotiation restart requests.
// Assumes the restart request is a level held until cleared.
`timescale 1ns/100ps
`default_nettype none
module neg_core_model #(parameter int DELAY = 4) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic negotiationRestart,
    output logic negRestartDone
);
    int cnt;
    // Delay keeps the request visible long enough to be seen
    always_ff @(posedge clk_sys) begin
        cnt <= (rst || !negotiationRestart || negRestartDone) ? 0 : cnt + 1;
        negRestartDone <= !rst && cnt == DELAY;
    end
endmodule : neg_core_model
`default_nettype wire

// [test/phy_basic_control_register_tb.sv]
// Self-checking bench for the basic control register.
// Drives the management port directly; a core model answers restarts.
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_register_tb;
    import phy_ctrl_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, negRestartDone, regRvalid;
    logic strapNegEnable = 1'b1, strapPowerDown = 1'b0, coreReset, loopbackEnable, speedReserved;
    logic negotiationEnable, softPowerDown, macIsolate, negotiationRestart, fullDuplexSelect, collisionTest;
    logic [1:0] strapSpeed = 2'h0, linkSpeed;
    logic [4:0] regAddr = 5'h00, ctl;
    logic [15:0] regWdata = 16'h0000, regRdata;
    int n_errors = 0, n_tests = 0;
    assign ctl = {loopbackEnable, negotiationEnable, softPowerDown, macIsolate, fullDuplexSelect};
    phy_basic_control_register DUT (.*);
    neg_core_model core (.*);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic test_done;
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitLow(ref logic sig);
        for (int i = 0; i < 60 && sig !== 1'b0; i++) @(posedge clk_sys);
        chk(16'(sig), 16'h0000);
        if (sig !== 1'b0) test_done();
    endtask : waitLow
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk(16'(regRvalid), 16'h0001);
        chk(regRdata, exp);
    endtask : rd
    task automatic doReset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : doReset
    task automatic t_defaults;
        rd(5'h00, CTRL_RESET);
        chk(16'({negotiationEnable, softPowerDown, linkSpeed}), 16'h0008);
        $display("defaults done");
    endtask : t_defaults
    task automatic t_fields;
        wr(5'h00, 16'h5DBF);
        rd(5'h00, 16'h5D80);
        chk(16'(ctl), 16'h001F);
        chk(16'(collisionTest), 16'h0001);
        wr(5'h01, 16'h0000);
        rd(5'h00, 16'h5D80);
        rd(5'h01, 16'h0000);
        wr(5'h00, 16'h0000);
        chk(16'(ctl), 16'h0000);
        chk(16'(collisionTest), 16'h0000);
        $display("fields done");
    endtask : t_fields
    task automatic t_speed;
        for (int c = 0; c < 4; c++) begin
            wr(5'h00, {2'h0, c[0], 6'h00, c[1], 6'h00});
            chk(16'({speedReserved, linkSpeed}), 16'({c[1], c[1:0]}));
        end
        $display("speed done");
    endtask : t_speed
    task automatic t_restart;
        wr(5'h00, 16'h0200);
        chk(16'(negotiationRestart), 16'h0001);
        waitLow(negotiationRestart);
        rd(5'h00, 16'h0000);
        $display("restart done");
    endtask : t_restart
    task automatic t_soft_reset;
        wr(5'h00, 16'h4100);
        wr(5'h00, 16'hC100);
        rd(5'h00, 16'hC100);
        waitLow(coreReset);
        repeat (6) @(posedge clk_sys);
        rd(5'h00, CTRL_RESET);
        chk(16'(ctl), 16'h0008);
        $display("soft reset done");
    endtask : t_soft_reset
    task automatic t_strap;
        strapPowerDown <= 1'b1;
        strapNegEnable <= 1'b0;
        strapSpeed <= 2'h1;
        doReset();
        rd(5'h00, 16'h2800);
        chk(16'(softPowerDown), 16'h0001);
        wr(5'h00, 16'h2000);
        chk(16'(softPowerDown), 16'h0000);
        $display("strap done");
    endtask : t_strap
    initial begin
        doReset();
        t_defaults();
        t_fields();
        t_speed();
        t_restart();
        t_soft_reset();
        t_strap();
        test_done();
    end
endmodule : phy_basic_control_register_tb
`default_nettype wire
